// ===== hdl/ptc_map.svh
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH
// ==========================================================
// register offsets
`define PTC_OFF_CTRL     8'h00
`define PTC_OFF_MODE     8'h04
`define PTC_OFF_COUNT    8'h08
`define PTC_OFF_LIMIT    8'h0c
`define PTC_OFF_FLAGS    8'h10
`define PTC_OFF_IMASK    8'h14
`define PTC_OFF_PERIPH   8'h18
`define PTC_OFF_CAPT     8'h1c
// ==========================================================
// field positions
`define PTC_CTRL_CLKEN   0
`define PTC_CTRL_DISABLE 1
`define PTC_CTRL_SWTRG   2
`define PTC_MODE_SEL_LSB 0
`define PTC_MODE_SEL_MSB 2
`define PTC_MODE_RESTART 14
`define PTC_MODE_WAVE    15
`define PTC_MODE_OUTA    16
`define PTC_MODE_OUTB    17
`define PTC_FLAG_OVF     0
`define PTC_FLAG_LOAD    1
`define PTC_FLAG_CMP     4
`define PTC_FLAG_CLKSTA  16
`define PTC_PERIPH_EN    0
// ==========================================================
// masks and reset values
`define PTC_MODE_MASK    32'h0003_c007
`define PTC_EVT_MASK     32'h0000_0013
`define PTC_MODE_RST     32'h0000_0000
`define PTC_LIMIT_RST    16'h0000
`define PTC_IMASK_RST    32'h0000_0000
`define PTC_COUNT_MAX    16'hffff
// ==========================================================
// clock select codes and divider taps
`define PTC_SEL_DIV2     3'h0
`define PTC_SEL_DIV8     3'h1
`define PTC_SEL_DIV128   3'h2
`define PTC_SEL_DIV1024  3'h3
`define PTC_SEL_SLOW     3'h4
`define PTC_DIV2_LOG     1
`define PTC_DIV8_LOG     3
`define PTC_DIV128_LOG   7
`define PTC_DIV1024_LOG  10
`define PTC_SLOW_HZ      32768
`define PTC_MAIN_CLK_HZ  250000000
// ==========================================================
// bus responses
`define PTC_RESP_OKAY    2'h0
`define PTC_RESP_SLVERR  2'h2
`endif

// ===== hdl/ptc_pkg.sv
package ptc_pkg;
   typedef logic [2:0]  ptc_sel_t;
   typedef logic [15:0] ptc_count_t;
   typedef enum logic {PTC_CAPTURE, PTC_WAVE} ptc_mode_t;
endpackage

// ===== hdl/ptc_tick_if.sv
`timescale 1ns/1ps
interface ptc_tick_if;
   import ptc_pkg::*;
   ptc_sel_t sel;
   logic     run;
   logic     slow_edge;
   logic     tick;
   modport prescale (input sel, input run, input slow_edge, output tick);
   modport core     (output sel, output run, output slow_edge, input tick);
endinterface

// ===== hdl/ptc_sync3.sv
`timescale 1ns/1ps
module ptc_sync3
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   import ptc_pkg::*;
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // ==========================================================
   // three-flop synchroniser, level accepted when 2 and 3 agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         level      <= 1'b0;
         rise       <= 1'b0;
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         rise       <= 1'b0;
         if (stage2_reg == stage3_reg)
         begin
            level <= stage3_reg;
            rise  <= stage3_reg & ~level;
         end
      end
   end
endmodule

// ===== hdl/ptc_prescale.sv
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_prescale
#(
   parameter int DIV_W = `PTC_DIV1024_LOG
)
(
   input  wire logic  aclk,
   input  wire logic  aresetn,
   ptc_tick_if.prescale tk
);
   import ptc_pkg::*;
   logic [DIV_W-1:0] div_reg;
   logic             tick_next;

   // ==========================================================
   // tap select
   always_comb
   begin
      case (tk.sel)
         `PTC_SEL_DIV2:    tick_next = &div_reg[`PTC_DIV2_LOG-1:0];
         `PTC_SEL_DIV8:    tick_next = &div_reg[`PTC_DIV8_LOG-1:0];
         `PTC_SEL_DIV128:  tick_next = &div_reg[`PTC_DIV128_LOG-1:0];
         `PTC_SEL_DIV1024: tick_next = &div_reg[`PTC_DIV1024_LOG-1:0];
         `PTC_SEL_SLOW:    tick_next = tk.slow_edge;
         default:          tick_next = 1'b0;
      endcase
   end

   // ==========================================================
   // divider frozen while peripheral clock is off
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_reg <= '0;
         tk.tick <= 1'b0;
      end
      else
      begin
         tk.tick <= tk.run & tick_next;
         if (tk.run)
         begin
            div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ===== hdl/ptc_top.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ptc_map.svh"
//Contract
// - no counting until the peripheral clock enable register is written
// - the clock disable bit stops the counter clock
// - mode register picks capture or waveform; compare works in both
// - waveform mode can drive the level toggled on each compare match onto output a or b
// - with restart set, counter returns to zero after reaching limit
// - input clock is master divided by 2, 8, 128, 1024 or slow clock
// - counter and limit are 16 bits wide
// - enabled compare flag raises the interrupt on a limit match
// - interrupt stays until the flags register is read
module ptc_top
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output ptc_pkg::ptc_count_t s_axi_rdata_lo,
   output logic [15:0]      s_axi_rdata_hi,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        slow_clk_in,
   input  wire logic        capture_in,
   output logic             wave_output_a,
   output logic             wave_output_b,
   output logic             irq
);
   import ptc_pkg::*;

   ptc_tick_if tk ();

   logic [7:0]  aw_addr_reg;
   logic        aw_pend_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        w_pend_reg;
   logic        wr_do;
   logic        rd_do;
   logic        wr_ok;
   logic [31:0] rd_val;
   logic        rd_ok;
   logic [31:0] mode_reg;
   ptc_count_t  limit_reg;
   logic [31:0] imask_reg;
   logic        periph_clock_enable_reg;
   logic        clk_en_reg;
   ptc_count_t  count_reg;
   ptc_count_t  count_next;
   ptc_count_t  capt_reg;
   logic [31:0] flags_reg;
   logic [31:0] flags_next;
   logic [31:0] evt;
   logic        wave_reg;
   logic        ctl_en;
   logic        ctl_dis;
   logic        ctl_trg;
   logic        step;
   logic        wrap;
   logic        cmp_evt;
   logic        ovf_evt;
   logic        load_evt;
   logic        flag_rd;
   logic        slow_rise;
   logic        capt_rise;
   ptc_mode_t   mode;

   // ==========================================================
   // byte-lane merge
   function automatic logic [31:0] merge
   (
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // pin synchronisers and prescaler
   ptc_sync3 u_slow_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (slow_clk_in),
      .level    (),
      .rise     (slow_rise)
   );

   ptc_sync3 u_capt_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (capture_in),
      .level    (),
      .rise     (capt_rise)
   );

   ptc_prescale u_prescale
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tk      (tk.prescale)
   );

   assign tk.sel = mode_reg[`PTC_MODE_SEL_MSB:`PTC_MODE_SEL_LSB];
   assign tk.run = periph_clock_enable_reg;
   assign tk.slow_edge = slow_rise;

   // ==========================================================
   // write channel: address and data in either order
   assign wr_do = aw_pend_reg & w_pend_reg & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_pend_reg   <= 1'b0;
         aw_addr_reg   <= 8'h00;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_pend_reg   <= 1'b1;
         aw_addr_reg   <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (wr_do)
      begin
         aw_pend_reg <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_pend_reg   <= 1'b0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_pend_reg   <= 1'b1;
         w_data_reg   <= s_axi_wdata;
         w_strb_reg   <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else if (wr_do)
      begin
         w_pend_reg <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   always_comb
   begin
      wr_ok = 1'b0;
      if (aw_addr_reg == `PTC_OFF_CTRL)
         wr_ok = 1'b1;
      else if (aw_addr_reg == `PTC_OFF_MODE)
         wr_ok = 1'b1;
      else if (aw_addr_reg == `PTC_OFF_LIMIT)
         wr_ok = 1'b1;
      else if (aw_addr_reg == `PTC_OFF_IMASK)
         wr_ok = 1'b1;
      else if (aw_addr_reg == `PTC_OFF_PERIPH)
         wr_ok = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PTC_RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // software-written registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg  <= `PTC_MODE_RST;
         limit_reg <= `PTC_LIMIT_RST;
         imask_reg <= `PTC_IMASK_RST;
         periph_clock_enable_reg <= 1'b0;
      end
      else if (wr_do)
      begin
         if (aw_addr_reg == `PTC_OFF_MODE)
            mode_reg <= merge(mode_reg, w_data_reg, w_strb_reg)
                        & `PTC_MODE_MASK;
         else if (aw_addr_reg == `PTC_OFF_LIMIT)
            limit_reg <= ptc_count_t'(merge({16'h0000, limit_reg},
                                            w_data_reg, w_strb_reg));
         else if (aw_addr_reg == `PTC_OFF_IMASK)
            imask_reg <= merge(imask_reg, w_data_reg, w_strb_reg)
                         & `PTC_EVT_MASK;
         else if (aw_addr_reg == `PTC_OFF_PERIPH &&
                  w_strb_reg[0] && w_data_reg[`PTC_PERIPH_EN])
            periph_clock_enable_reg <= 1'b1;
      end
   end

   // control command pulses
   always_comb
   begin
      ctl_en  = 1'b0;
      ctl_dis = 1'b0;
      ctl_trg = 1'b0;
      if (wr_do && aw_addr_reg == `PTC_OFF_CTRL && w_strb_reg[0])
      begin
         ctl_en  = w_data_reg[`PTC_CTRL_CLKEN];
         ctl_dis = w_data_reg[`PTC_CTRL_DISABLE];
         ctl_trg = w_data_reg[`PTC_CTRL_SWTRG];
      end
   end

   // ==========================================================
   // channel clock enable, disable wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_en_reg <= 1'b0;
      else if (ctl_dis)
         clk_en_reg <= 1'b0;
      else if (ctl_en)
         clk_en_reg <= 1'b1;
   end

   // ==========================================================
   // counter
   assign mode = mode_reg[`PTC_MODE_WAVE] ? PTC_WAVE : PTC_CAPTURE;
   assign step = tk.tick & clk_en_reg & periph_clock_enable_reg;
   assign wrap = mode_reg[`PTC_MODE_RESTART] &&
                 (count_reg == limit_reg);

   always_comb
   begin
      count_next = count_reg;
      if (step)
      begin
         if (wrap)
            count_next = 16'h0000;
         else
            count_next = count_reg + 16'h0001;
      end
   end

   assign cmp_evt = step && (count_next == limit_reg);
   assign ovf_evt = step && !wrap && (count_reg == `PTC_COUNT_MAX);
   assign load_evt = capt_rise && (mode == PTC_CAPTURE) &&
                     clk_en_reg && periph_clock_enable_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_reg <= 16'h0000;
      else if (ctl_trg && !ctl_dis && (clk_en_reg || ctl_en))
         count_reg <= 16'h0000;
      else
         count_reg <= count_next;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         capt_reg <= 16'h0000;
      else if (load_evt)
         capt_reg <= count_reg;
   end

   // ==========================================================
   // waveform outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wave_reg      <= 1'b0;
         wave_output_a <= 1'b0;
         wave_output_b <= 1'b0;
      end
      else
      begin
         if (cmp_evt && mode == PTC_WAVE)
            wave_reg <= ~wave_reg;
         wave_output_a <= (mode == PTC_WAVE) &&
                          mode_reg[`PTC_MODE_OUTA] && wave_reg;
         wave_output_b <= (mode == PTC_WAVE) &&
                          mode_reg[`PTC_MODE_OUTB] && wave_reg;
      end
   end

   // ==========================================================
   // read channel
   assign rd_do   = s_axi_arvalid & s_axi_arready;
   assign flag_rd = rd_do && (s_axi_araddr == `PTC_OFF_FLAGS);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (s_axi_araddr == `PTC_OFF_CTRL)
         rd_val = 32'h0000_0000;
      else if (s_axi_araddr == `PTC_OFF_MODE)
         rd_val = mode_reg;
      else if (s_axi_araddr == `PTC_OFF_COUNT)
         rd_val = {16'h0000, count_reg};
      else if (s_axi_araddr == `PTC_OFF_LIMIT)
         rd_val = {16'h0000, limit_reg};
      else if (s_axi_araddr == `PTC_OFF_FLAGS)
         rd_val = flags_reg | ({31'h0, clk_en_reg} << `PTC_FLAG_CLKSTA);
      else if (s_axi_araddr == `PTC_OFF_IMASK)
         rd_val = imask_reg;
      else if (s_axi_araddr == `PTC_OFF_PERIPH)
         rd_val = {31'h0, periph_clock_enable_reg};
      else if (s_axi_araddr == `PTC_OFF_CAPT)
         rd_val = {16'h0000, capt_reg};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready  <= 1'b1;
         s_axi_rvalid   <= 1'b0;
         s_axi_rdata_lo <= 16'h0000;
         s_axi_rdata_hi <= 16'h0000;
         s_axi_rresp    <= `PTC_RESP_OKAY;
      end
      else if (rd_do)
      begin
         s_axi_arready  <= 1'b0;
         s_axi_rvalid   <= 1'b1;
         s_axi_rdata_lo <= rd_val[15:0];
         s_axi_rdata_hi <= rd_val[31:16];
         s_axi_rresp    <= rd_ok ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // ==========================================================
   // sticky flags, set wins over read clear
   always_comb
   begin
      evt                = 32'h0000_0000;
      evt[`PTC_FLAG_OVF]  = ovf_evt;
      evt[`PTC_FLAG_LOAD] = load_evt;
      evt[`PTC_FLAG_CMP]  = cmp_evt;
      flags_next = (flag_rd ? 32'h0000_0000 : flags_reg) | evt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flags_reg <= 32'h0000_0000;
         irq       <= 1'b0;
      end
      else
      begin
         flags_reg <= flags_next;
         irq       <= |(flags_next & imask_reg);
      end
   end
endmodule

// ===== testbench/ptc_top_assertions.sv
`timescale 1ns/1ps
`include "ptc_map.svh"
// ==================================================================
// bus and interrupt checks
module ptc_top_checker
(
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic [7:0]          s_axi_awaddr,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic [7:0]          s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire ptc_pkg::ptc_count_t s_axi_rdata_lo,
   input wire logic [15:0]         s_axi_rdata_hi,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic                irq
);
   import ptc_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd_flags;
   assign rd_flags = s_axi_arvalid && s_axi_arready
                     && s_axi_araddr == `PTC_OFF_FLAGS;
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_irq_holds: assert property (irq && s_axi_awready && !rd_flags
      && !$past(rd_flags) |=> irq) else $error("irq dropped unread");
   a_irq_reset: assert property ($rose(aresetn) |-> !irq)
      else $error("irq high after reset");
   a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid
      && !s_axi_arready) else $error("read response late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable({s_axi_rdata_hi, s_axi_rdata_lo,
      s_axi_rresp})) else $error("r dropped");
   a_unmapped_rd: assert property (s_rd_take ##0 s_axi_araddr > 8'h1c
      |=> s_axi_rresp == `PTC_RESP_SLVERR
      && {s_axi_rdata_hi, s_axi_rdata_lo} == 32'h0)
      else $error("unmapped read not refused");
   a_ro_write: assert property (s_wr_take ##0 s_axi_awaddr ==
      `PTC_OFF_COUNT |-> ##2 s_axi_bresp == `PTC_RESP_SLVERR)
      else $error("read-only write not refused");
endmodule
bind ptc_top ptc_top_checker u_ptc_top_checker
(
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata_lo, .s_axi_rdata_hi, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .irq
);

// ===== testbench/ptc_far_model.sv
`timescale 1ns/1ps
// ==================================================================
// slow oscillator and level-sensitive interrupt controller view
module ptc_far_model
#(
   parameter int HALF = 4
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic irq,
   output logic      slow_clk_in,
   output logic      pend
);
   int ph = 0;
   initial slow_clk_in = 1'b0;
   initial pend = 1'b0;
   // free-running, scaled down to keep runs short
   always @(posedge aclk)
   begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
         slow_clk_in <= ~slow_clk_in;
   end
   // pending while the line is high, no edge memory
   always @(posedge aclk)
      pend <= aresetn && irq;
endmodule

// ===== testbench/ptc_top_tb.sv
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_top_tb;
   import ptc_pkg::*;
   // ===============================================================
   // signals
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, capture_in, slow_clk_in;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, wave_output_a, wave_output_b, irq, pend;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] s_axi_rdata_hi;
   ptc_count_t  s_axi_rdata_lo;
   int          err_total = 0;
   int          n_compared = 0;
   localparam logic [1:0] OK = `PTC_RESP_OKAY;
   localparam logic [1:0] ER = `PTC_RESP_SLVERR;
   ptc_top u_ptc_top
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata_lo, .s_axi_rdata_hi, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .slow_clk_in, .capture_in, .wave_output_a,
      .wave_output_b, .irq
   );
   ptc_far_model #(.HALF(4)) u_ptc_far_model
   (
      .aclk, .aresetn, .irq, .slow_clk_in, .pend
   );
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ===============================================================
   // tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask
   task automatic late(input int n);
      if (n >= 200)
      begin
         err_total++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er, input int hold = 0);
      int n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (hold == 0);
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         n++;
         if (n == hold)
            s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
      late(n);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] er, input int hold = 0);
      int n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= (hold == 0);
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         n++;
         if (n == hold)
            s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
      late(n);
      d = {s_axi_rdata_hi, s_axi_rdata_lo};
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   function automatic logic lvl(input int j);
      return j == 0 ? wave_output_a : j == 1 ? wave_output_b : pend;
   endfunction
   task automatic watch(input int j, input logic from);
      int n = 0;
      while (lvl(j) === from && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      late(n);
   endtask
   // ===============================================================
   // scenarios
   initial
   begin
      logic [31:0] v;
      logic [31:0] w;
      logic        b;
      int          dv [5];
      dv = '{2, 8, 128, 1024, 8};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, aresetn} = '0;
      {s_axi_arvalid, s_axi_rready, capture_in} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a < 32; a += 4)
      begin
         rd(8'(a), v, OK);
         chk(v, 32'h0);
      end
      wr(`PTC_OFF_LIMIT, 32'hffff_ffff, OK);
      rd(`PTC_OFF_LIMIT, v, OK);
      chk(v, 32'h0000_ffff);
      wr(`PTC_OFF_MODE, 32'hffff_ffff, OK);
      rd(`PTC_OFF_MODE, v, OK);
      chk(v, `PTC_MODE_MASK);
      wr(`PTC_OFF_MODE, 32'h0, OK);
      wr(`PTC_OFF_CTRL, 32'h1, OK);
      cyc(20);
      rd(`PTC_OFF_COUNT, v, OK);
      chk(v, 32'h0);
      wr(8'h18, 32'h1, OK);
      cyc(20);
      wr(`PTC_OFF_CTRL, 32'h2, OK);
      rd(`PTC_OFF_COUNT, v, OK);
      chk(32'(v != 0), 32'h1);
      cyc(20);
      rd(`PTC_OFF_COUNT, w, OK);
      chk(w, v);
      for (int i = 0; i < 5; i++)
      begin
         wr(`PTC_OFF_MODE, 32'(i), OK);
         wr(`PTC_OFF_CTRL, 32'h5, OK);
         cyc(8 * dv[i]);
         wr(`PTC_OFF_CTRL, 32'h2, OK);
         rd(`PTC_OFF_COUNT, v, OK);
         chk(32'(v >= 7 && v <= 24 / dv[i] + 9), 32'h1);
      end
      wr(`PTC_OFF_LIMIT, 32'h5, OK);
      wr(`PTC_OFF_IMASK, 32'h10, OK);
      for (int j = 0; j < 2; j++)
      begin
         wr(`PTC_OFF_CTRL, 32'h2, OK);
         wr(`PTC_OFF_MODE, 32'hc000 | (32'h1_0000 << j), OK);
         rd(`PTC_OFF_FLAGS, v, OK);
         wr(`PTC_OFF_CTRL, 32'h5, OK);
         watch(2, 1'b0);
         rd(`PTC_OFF_FLAGS, v, OK);
         chk(v & 32'h10, 32'h10);
         chk(irq, 1'b0);
         watch(j, lvl(j));
         b = lvl(j);
         cyc(11);
         chk(lvl(j), b);
         cyc(1);
         chk(lvl(j), !b);
         chk(lvl(1 - j), 1'b0);
      end
      wr(`PTC_OFF_IMASK, 32'h0, OK);
      rd(`PTC_OFF_FLAGS, v, OK);
      cyc(30);
      chk(irq, 1'b0);
      rd(`PTC_OFF_FLAGS, v, OK);
      chk(v & 32'h10, 32'h10);
      wr(`PTC_OFF_CTRL, 32'h2, OK);
      wr(`PTC_OFF_MODE, 32'h4000, OK);
      wr(`PTC_OFF_CTRL, 32'h5, OK);
      capture_in <= 1'b1;
      cyc(8);
      capture_in <= 1'b0;
      cyc(20);
      rd(`PTC_OFF_FLAGS, v, OK);
      chk(v & 32'h1_0012, 32'h1_0012);
      chk({wave_output_a, wave_output_b}, 2'b0);
      rd(`PTC_OFF_CAPT, v, OK);
      chk(32'(v <= 5), 32'h1);
      wr(`PTC_OFF_CTRL, 32'h2, OK);
      wr(`PTC_OFF_MODE, 32'h4000 | `PTC_SEL_SLOW, OK);
      wr(`PTC_OFF_LIMIT, `PTC_SLOW_HZ >> 2, OK);
      rd(`PTC_OFF_LIMIT, v, OK);
      chk(v, 32'h0000_2000);
      rd(8'h20, v, ER, 3);
      chk(v, 32'h0);
      wr(`PTC_OFF_COUNT, 32'h1, ER, 3);
      wr(8'h3c, 32'h1, ER);
      results();
   end
endmodule
